// >>> i2c_host_model.sv
// Host-side serial master that reaches the thermal register bank
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model #(
  parameter logic [6:0] TARGET = 7'h2A
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // Bus idles released; the host drives the clock high and the pull-up keeps data high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Four-clock phases leave room for the one-clock ack delay
  task automatic clock_bit(input logic b, output logic seen);
    sda_low <= ~b;
    hold(4);
    scl <= 1'b1;
    hold(2);
    seen = sda_line;
    hold(2);
    scl <= 1'b0;
    hold(1);
  endtask

  // Works as first or repeated start: release, raise clock, pull data
  task automatic start_cond();
    sda_low <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(4);
    sda_low <= 1'b1;
    hold(4);
    scl <= 1'b0;
    hold(1);
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(4);
    sda_low <= 1'b0;
    hold(4);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) clock_bit(v[i], seen);
    clock_bit(1'b1, seen);
    acked = ~seen;
  endtask

  task automatic recv_byte(input logic ack_it, output logic [7:0] v);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, seen);
      v[i] = seen;
    end
    clock_bit(~ack_it, seen);
  endtask

  task automatic write_bytes(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] d [4], input int n,
                             output logic ok);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, ok);
    send_byte(ptr, a);
    ok = ok & a;
    for (int k = 0; k < n; k++) begin
      send_byte(d[k], a);
      ok = ok & a;
    end
    stop_cond();
  endtask

  // Last byte is refused by the host so the target lets go of the line
  task automatic read_bytes(input logic [7:0] ptr, input int n,
                            output logic [7:0] q [6], output logic ok);
    logic a;
    start_cond();
    send_byte({TARGET, 1'b0}, ok);
    send_byte(ptr, a);
    ok = ok & a;
    start_cond();
    send_byte({TARGET, 1'b1}, a);
    ok = ok & a;
    for (int k = 0; k < n; k++) recv_byte(k < n - 1, q[k]);
    stop_cond();
  endtask
endmodule

`default_nettype wire

// >>> thermal_charge_adc_enable_regs.sv
// Serial-reachable channel enable and thermal charge control registers
`timescale 1ns/100ps
`default_nettype none
`include "thermal_defs.svh"

module thermal_charge_adc_enable_regs
  import thermal_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR   = 7'h2A, // Arbitrary value
  parameter logic [7:0] PART_ID_VALUE = 8'h5A  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] therm_code,
  input  wire logic       therm_valid,
  output logic            input_current_channel_on,
  output logic            system_rail_channel_on,
  output logic            charge_current_channel_on,
  output logic            input_voltage_channel_on,
  output logic            battery_voltage_channel_on,
  output logic            thermistor_channel_on,
  output logic            aux_input_channel_on,
  output region_t         battery_region,
  output logic [8:0]      voltage_reduction_mv,
  output logic [3:0]      current_scale_eighths,
  output logic            charge_suspended
);

  logic          scl_q;
  logic          sda_q;
  serial_state_t state;
  serial_state_t next_state;
  logic [3:0]    bit_count;
  logic [3:0]    next_bit_count;
  logic [7:0]    shift;
  logic [7:0]    next_shift;
  logic [7:0]    pointer;
  logic [7:0]    next_pointer;
  logic [7:0]    tx;
  logic [7:0]    next_tx;
  logic          drive_low;
  logic          next_drive_low;
  logic          wr_stb;
  logic [7:0]    rd_data;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;

  logic [7:0]    converter_channel_enables;
  logic [7:0]    thermal_charge_reduction;
  logic [7:0]    cold_threshold;
  logic [7:0]    cool_threshold;
  logic [7:0]    warm_threshold;
  logic [7:0]    hot_threshold;
  logic [7:0]    next_enables;
  logic [7:0]    next_reduction;
  logic [7:0]    next_cold;
  logic [7:0]    next_cool;
  logic [7:0]    next_warm;
  logic [7:0]    next_hot;

  logic          cold_hit;
  logic          cool_hit;
  logic          warm_hit;
  logic          hot_hit;
  region_t       next_region;
  logic [8:0]    next_vred;
  logic [3:0]    next_iscale;
  logic [2:0]    vred_code;
  logic [2:0]    iscale_code;

  // Pins are synchronous, so one stage of history is enough for edges
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    case (pointer)
      `OFS_CHANNEL_ENABLES:   rd_data = converter_channel_enables;
      `OFS_THERMAL_REDUCTION: rd_data = thermal_charge_reduction;
      `OFS_COLD_THRESHOLD:    rd_data = cold_threshold;
      `OFS_COOL_THRESHOLD:    rd_data = cool_threshold;
      `OFS_WARM_THRESHOLD:    rd_data = warm_threshold;
      `OFS_HOT_THRESHOLD:     rd_data = hot_threshold;
      `OFS_PART_IDENTIFIER:   rd_data = PART_ID_VALUE;
      default:                rd_data = `READ_UNMAPPED;
    endcase
  end

  // Serial target sequencing: address, pointer, then data bytes
  always_comb begin
    next_state     = state;
    next_bit_count = bit_count;
    next_shift     = shift;
    next_pointer   = pointer;
    next_tx        = tx;
    next_drive_low = drive_low;
    wr_stb         = 1'b0;
    if (start_seen) begin
      next_state     = st_addr;
      next_bit_count = 4'h0;
      next_drive_low = 1'b0;
    end else if (stop_seen) begin
      next_state     = st_idle;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        st_addr, st_ptr, st_wdata: begin
          if (scl_rise) begin
            next_shift     = {shift[6:0], sda_in};
            next_bit_count = bit_count + 4'h1;
          end
          if (scl_fall && bit_count == `BYTE_BITS) begin
            next_bit_count = 4'h0;
            next_drive_low = 1'b1;
            if (state == st_addr) begin
              // Foreign address: stay off the bus until the next start
              if (shift[7:1] == TARGET_ADDR) begin
                next_state = st_addr_ack;
              end else begin
                next_state     = st_idle;
                next_drive_low = 1'b0;
              end
            end else if (state == st_ptr) begin
              next_pointer = shift;
              next_state   = st_ptr_ack;
            end else begin
              wr_stb     = 1'b1;
              next_state = st_wdata_ack;
            end
          end
        end
        st_addr_ack: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_state     = st_ptr;
            if (shift[0]) begin
              next_tx        = rd_data;
              next_drive_low = ~rd_data[7];
              next_bit_count = 4'h1;
              next_state     = st_rdata;
            end
          end
        end
        st_ptr_ack: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_state     = st_wdata;
          end
        end
        st_wdata_ack: begin
          // Pointer advances so bursts fill consecutive offsets
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_pointer   = pointer + 8'h01;
            next_state     = st_wdata;
          end
        end
        st_rdata: begin
          if (scl_fall) begin
            if (bit_count == `BYTE_BITS) begin
              next_drive_low = 1'b0;
              next_state     = st_rdata_ack;
            end else begin
              next_drive_low = ~tx[6];
              next_tx        = {tx[6:0], 1'b0};
              next_bit_count = bit_count + 4'h1;
            end
          end
        end
        st_rdata_ack: begin
          if (scl_rise) begin
            if (sda_in) begin
              next_state = st_idle;
            end else begin
              next_pointer = pointer + 8'h01;
            end
          end else if (scl_fall) begin
            next_tx        = rd_data;
            next_drive_low = ~rd_data[7];
            next_bit_count = 4'h1;
            next_state     = st_rdata;
          end
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      state     <= st_idle;
      bit_count <= 4'h0;
      shift     <= 8'h00;
      pointer   <= 8'h00;
      tx        <= 8'h00;
      drive_low <= 1'b0;
    end else begin
      scl_q     <= scl_in;
      sda_q     <= sda_in;
      state     <= next_state;
      bit_count <= next_bit_count;
      shift     <= next_shift;
      pointer   <= next_pointer;
      tx        <= next_tx;
      drive_low <= next_drive_low;
    end
  end

  // Register writes; reserved bits are stored as written
  always_comb begin
    next_enables   = converter_channel_enables;
    next_reduction = thermal_charge_reduction;
    next_cold      = cold_threshold;
    next_cool      = cool_threshold;
    next_warm      = warm_threshold;
    next_hot       = hot_threshold;
    if (wr_stb) begin
      case (pointer)
        `OFS_CHANNEL_ENABLES:   next_enables   = shift;
        `OFS_THERMAL_REDUCTION: next_reduction = shift;
        `OFS_COLD_THRESHOLD:    next_cold      = shift;
        `OFS_COOL_THRESHOLD:    next_cool      = shift;
        `OFS_WARM_THRESHOLD:    next_warm      = shift;
        `OFS_HOT_THRESHOLD:     next_hot       = shift;
        default:                next_enables   = converter_channel_enables;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      converter_channel_enables <= `RST_CHANNEL_ENABLES;
      thermal_charge_reduction  <= `RST_THERMAL_REDUCTION;
      cold_threshold            <= `RST_COLD_THRESHOLD;
      cool_threshold            <= `RST_COOL_THRESHOLD;
      warm_threshold            <= `RST_WARM_THRESHOLD;
      hot_threshold             <= `RST_HOT_THRESHOLD;
    end else begin
      converter_channel_enables <= next_enables;
      thermal_charge_reduction  <= next_reduction;
      cold_threshold            <= next_cold;
      cool_threshold            <= next_cool;
      warm_threshold            <= next_warm;
      hot_threshold             <= next_hot;
    end
  end

  assign input_current_channel_on   =
    converter_channel_enables[`BIT_INPUT_CURRENT];
  assign system_rail_channel_on     =
    converter_channel_enables[`BIT_SYSTEM_RAIL];
  assign charge_current_channel_on  =
    converter_channel_enables[`BIT_CHARGE_CURRENT];
  assign input_voltage_channel_on   =
    converter_channel_enables[`BIT_INPUT_VOLTAGE];
  assign battery_voltage_channel_on =
    converter_channel_enables[`BIT_BATTERY_VOLTAGE];
  assign thermistor_channel_on      =
    converter_channel_enables[`BIT_THERMISTOR];
  assign aux_input_channel_on       =
    converter_channel_enables[`BIT_AUX_INPUT];

  threshold_compare #(.ABOVE(1'b1)) u_cold (
    .value(therm_code), .threshold(cold_threshold), .hit(cold_hit));
  threshold_compare #(.ABOVE(1'b1)) u_cool (
    .value(therm_code), .threshold(cool_threshold), .hit(cool_hit));
  threshold_compare #(.ABOVE(1'b0)) u_warm (
    .value(therm_code), .threshold(warm_threshold), .hit(warm_hit));
  threshold_compare #(.ABOVE(1'b0)) u_hot (
    .value(therm_code), .threshold(hot_threshold), .hit(hot_hit));

  assign vred_code   = thermal_charge_reduction[`VRED_MSB:`VRED_LSB];
  assign iscale_code = thermal_charge_reduction[`ISCALE_MSB:`ISCALE_LSB];

  // Region held between samples; channel off means no thermal action
  always_comb begin
    next_region = battery_region;
    if (!thermistor_channel_on) begin
      next_region = region_normal;
    end else if (therm_valid) begin
      if (hot_hit) begin
        next_region = region_hot;
      end else if (cold_hit) begin
        next_region = region_cold;
      end else if (warm_hit) begin
        next_region = region_warm;
      end else if (cool_hit) begin
        next_region = region_cool;
      end else begin
        next_region = region_normal;
      end
    end
    next_vred = (battery_region == region_warm) ?
                ({6'h00, vred_code} * `WARM_STEP_MV) : 9'h000;
    next_iscale = `FULL_SCALE_EIGHTHS;
    if (battery_region == region_cool || battery_region == region_warm) begin
      next_iscale = `FULL_SCALE_EIGHTHS - {1'b0, iscale_code};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      battery_region        <= region_normal;
      voltage_reduction_mv  <= 9'h000;
      current_scale_eighths <= `FULL_SCALE_EIGHTHS;
      charge_suspended      <= 1'b0;
    end else begin
      battery_region        <= next_region;
      voltage_reduction_mv  <= next_vred;
      current_scale_eighths <= next_iscale;
      charge_suspended      <= (battery_region == region_cold) ||
                               (battery_region == region_hot);
    end
  end

  property p_enables_reset;
    @(posedge clk) disable iff (rst)
      $past(rst) |-> converter_channel_enables == `RST_CHANNEL_ENABLES;
  endproperty
  a_enables_reset: assert property (p_enables_reset)
    else $error("enables not cleared by reset");

  property p_upper_enables_write;
    @(posedge clk) disable iff (rst)
      (wr_stb && pointer == `OFS_CHANNEL_ENABLES) |=>
        {input_current_channel_on, system_rail_channel_on,
         charge_current_channel_on} == $past(shift[7:5]);
  endproperty
  a_upper_enables_write: assert property (p_upper_enables_write)
    else $error("upper channel enables not written");

  property p_voltage_enables_write;
    @(posedge clk) disable iff (rst)
      (wr_stb && pointer == `OFS_CHANNEL_ENABLES) |=>
        {input_voltage_channel_on, battery_voltage_channel_on}
          == $past(shift[4:3]);
  endproperty
  a_voltage_enables_write: assert property (p_voltage_enables_write)
    else $error("voltage channel enables not written");

  property p_low_enables_write;
    @(posedge clk) disable iff (rst)
      (wr_stb && pointer == `OFS_CHANNEL_ENABLES) |=>
        converter_channel_enables[2:0] == $past(shift[2:0]);
  endproperty
  a_low_enables_write: assert property (p_low_enables_write)
    else $error("low enable bits not written");

  property p_warm_reduction;
    @(posedge clk) disable iff (rst)
      battery_region == region_warm |=>
        voltage_reduction_mv == $past(vred_code) * `WARM_STEP_MV;
  endproperty
  a_warm_reduction: assert property (p_warm_reduction)
    else $error("warm voltage reduction wrong");

  property p_current_scale;
    @(posedge clk) disable iff (rst)
      (battery_region == region_cool || battery_region == region_warm) |=>
        current_scale_eighths == `FULL_SCALE_EIGHTHS - $past(iscale_code);
  endproperty
  a_current_scale: assert property (p_current_scale)
    else $error("reduced current scale wrong");

  property p_cold_write;
    @(posedge clk) disable iff (rst)
      (wr_stb && pointer == `OFS_COLD_THRESHOLD) |=>
        cold_threshold == $past(shift);
  endproperty
  a_cold_write: assert property (p_cold_write)
    else $error("cold threshold not written");

  property p_hot_region;
    @(posedge clk) disable iff (rst)
      (therm_valid && thermistor_channel_on &&
       therm_code <= hot_threshold) |=>
        battery_region == region_hot ##1 charge_suspended;
  endproperty
  a_hot_region: assert property (p_hot_region)
    else $error("hot region not entered");

endmodule

`default_nettype wire

// >>> thermal_charge_adc_enable_regs_tb.sv
// Self-checking bench for the thermal charge register bank
`timescale 1ns/100ps
`default_nettype none
`include "thermal_defs.svh"

`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module thermal_charge_adc_enable_regs_tb
  import thermal_pkg::*;
;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [7:0] ID_VALUE = 8'hA5; // Arbitrary value
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [6:0] en_exp;
  } row_t;
  typedef struct packed {
    logic [7:0] level;
    region_t    region;
    logic [8:0] vred;
    logic [3:0] scale;
    logic       susp;
  } therm_t;

  logic clk, rst, scl, host_low, sda_line, sda_out, sda_oe, therm_valid, ok;
  logic [7:0] therm_code;
  logic [6:0] en_seen;
  logic       i_on, r_on, c_on, v_on, b_on, t_on, a_on, susp;
  region_t    region;
  logic [8:0] vred;
  logic [3:0] scale;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [6];
  int         err_count = 0;
  int         n_compared = 0;
  logic [7:0] dflt [6] = '{8'h34, 8'h7C, 8'h6D, 8'h38, 8'h27, 8'h00};
  row_t rows [8] = '{
    '{8'h58, 8'hE0, 8'hE0, 7'h70}, '{8'h58, 8'h18, 8'h18, 7'h0C},
    '{8'h58, 8'h06, 8'h06, 7'h03}, '{8'h58, 8'h01, 8'h01, 7'h00},
    '{8'h58, 8'hFF, 8'hFF, 7'h7F}, '{8'h61, 8'hFF, 8'hFF, 7'h7F},
    '{8'h6F, 8'h00, ID_VALUE, 7'h7F}, '{8'h70, 8'h55, 8'h00, 7'h7F}};
  // Threshold edges at defaults, reduction register set to 0x52
  therm_t tcase [10] = '{
    '{8'h27, region_hot, 9'd0, 4'h8, 1'b1},
    '{8'h00, region_hot, 9'd0, 4'h8, 1'b1},
    '{8'h28, region_warm, 9'd250, 4'h6, 1'b0},
    '{8'h38, region_warm, 9'd250, 4'h6, 1'b0},
    '{8'h39, region_normal, 9'd0, 4'h8, 1'b0},
    '{8'h6C, region_normal, 9'd0, 4'h8, 1'b0},
    '{8'h6D, region_cool, 9'd0, 4'h6, 1'b0},
    '{8'h7B, region_cool, 9'd0, 4'h6, 1'b0},
    '{8'h7C, region_cold, 9'd0, 4'h8, 1'b1},
    '{8'hFF, region_cold, 9'd0, 4'h8, 1'b1}};

  // Open-drain data line with pull-up; host owns the serial clock
  assign sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  assign en_seen  = {i_on, r_on, c_on, v_on, b_on, t_on, a_on};

  i2c_host_model #(.TARGET(DEV_ADDR)) i2c_host_model_i (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));

  thermal_charge_adc_enable_regs #(
    .TARGET_ADDR(DEV_ADDR), .PART_ID_VALUE(ID_VALUE)
  ) thermal_charge_adc_enable_regs_i (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .therm_code(therm_code),
    .therm_valid(therm_valid), .input_current_channel_on(i_on),
    .system_rail_channel_on(r_on), .charge_current_channel_on(c_on),
    .input_voltage_channel_on(v_on), .battery_voltage_channel_on(b_on),
    .thermistor_channel_on(t_on), .aux_input_channel_on(a_on),
    .battery_region(region), .voltage_reduction_mv(vred),
    .current_scale_eighths(scale), .charge_suspended(susp));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic put(input logic [7:0] ptr, input logic [7:0] v);
    wbuf[0] = v;
    i2c_host_model_i.write_bytes(DEV_ADDR, ptr, wbuf, 1, ok);
  endtask

  // Output latency is fixed: region one clock, reductions two
  task automatic sample(input logic [7:0] v);
    therm_code  <= v;
    therm_valid <= 1'b1;
    @(posedge clk);
    therm_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic check_defaults();
    `CHK("enables", 7'h00, en_seen)
    `CHK("region", region_normal, region)
    `CHK("scale", 4'h8, scale)
    `CHK("suspend", 1'b0, susp)
    i2c_host_model_i.read_bytes(`OFS_CHANNEL_ENABLES, 1, rbuf, ok);
    `CHK("enable reg", 8'h00, rbuf[0])
    i2c_host_model_i.read_bytes(8'h61, 6, rbuf, ok);
    for (int k = 0; k < 6; k++) `CHK("default", dflt[k], rbuf[k])
  endtask

  // Hang guard: running out counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    therm_code = 8'h00;
    therm_valid = 1'b0;
    do_reset();
    check_defaults();
    foreach (rows[r]) begin
      put(rows[r].ptr, rows[r].wdata);
      `CHK("write ack", 1'b1, ok)
      i2c_host_model_i.read_bytes(rows[r].ptr, 1, rbuf, ok);
      `CHK("readback", rows[r].rexp, rbuf[0])
      `CHK("enables", rows[r].en_exp, en_seen)
    end
    // Wrong address is refused and leaves the register alone
    wbuf[0] = 8'h11;
    i2c_host_model_i.write_bytes(7'h2B, 8'h62, wbuf, 1, ok);
    `CHK("foreign ack", 1'b0, ok)
    i2c_host_model_i.read_bytes(8'h62, 1, rbuf, ok);
    `CHK("foreign untouched", 8'h7C, rbuf[0])
    // Burst write walks the pointer through all four thresholds
    wbuf = '{8'h80, 8'h70, 8'h30, 8'h20};
    i2c_host_model_i.write_bytes(DEV_ADDR, 8'h62, wbuf, 4, ok);
    i2c_host_model_i.read_bytes(8'h62, 4, rbuf, ok);
    for (int k = 0; k < 4; k++) `CHK("threshold", wbuf[k], rbuf[k])
    // Mid-run reset must restore every default
    do_reset();
    check_defaults();
    put(`OFS_CHANNEL_ENABLES, 8'h04);
    put(8'h61, 8'h52);
    foreach (tcase[t]) begin
      sample(tcase[t].level);
      `CHK("region", tcase[t].region, region)
      `CHK("vred", tcase[t].vred, vred)
      `CHK("scale", tcase[t].scale, scale)
      `CHK("suspend", tcase[t].susp, susp)
    end
    // Every reduction code while warm
    for (int c = 0; c < 8; c++) begin
      put(8'h61, {1'b0, 3'(c), 1'b0, 3'(c)});
      sample(8'h30);
      `CHK("vred code", 9'(50 * c), vred)
      `CHK("scale code", 4'(8 - c), scale)
    end
    // Region holds without a fresh sample
    sample(8'h00);
    therm_code <= 8'hFF;
    repeat (4) @(posedge clk);
    `CHK("region hold", region_hot, region)
    // Thermistor channel off means no thermal action
    put(`OFS_CHANNEL_ENABLES, 8'h00);
    sample(8'h00);
    `CHK("region off", region_normal, region)
    `CHK("suspend off", 1'b0, susp)
    close_out();
  end
endmodule

`default_nettype wire

// >>> thermal_defs.svh
// Register map, reset values, field positions and scaling constants
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH

`define OFS_CHANNEL_ENABLES   8'h58
`define OFS_THERMAL_REDUCTION 8'h61
`define OFS_COLD_THRESHOLD    8'h62
`define OFS_COOL_THRESHOLD    8'h63
`define OFS_WARM_THRESHOLD    8'h64
`define OFS_HOT_THRESHOLD     8'h65
`define OFS_PART_IDENTIFIER   8'h6F

`define RST_CHANNEL_ENABLES   8'h00
`define RST_THERMAL_REDUCTION 8'h34
`define RST_COLD_THRESHOLD    8'h7C
`define RST_COOL_THRESHOLD    8'h6D
`define RST_WARM_THRESHOLD    8'h38
`define RST_HOT_THRESHOLD     8'h27

`define BIT_INPUT_CURRENT     7
`define BIT_SYSTEM_RAIL       6
`define BIT_CHARGE_CURRENT    5
`define BIT_INPUT_VOLTAGE     4
`define BIT_BATTERY_VOLTAGE   3
`define BIT_THERMISTOR        2
`define BIT_AUX_INPUT         1
`define VRED_MSB              6
`define VRED_LSB              4
`define ISCALE_MSB            2
`define ISCALE_LSB            0

`define WARM_STEP_MV          9'd50
`define FULL_SCALE_EIGHTHS    4'h8
`define BYTE_BITS             4'h8
`define READ_UNMAPPED         8'h00

`endif

// >>> thermal_pkg.sv
// Types shared by the thermal register bank
package thermal_pkg;

  typedef enum logic [2:0] {
    region_normal,
    region_cold,
    region_cool,
    region_warm,
    region_hot
  } region_t;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_ptr,
    st_ptr_ack,
    st_wdata,
    st_wdata_ack,
    st_rdata,
    st_rdata_ack
  } serial_state_t;

endpackage

// >>> threshold_compare.sv
// Single thermistor threshold comparator
`timescale 1ns/100ps
`default_nettype none

module threshold_compare #(
  parameter bit ABOVE = 1'b1
) (
  input  wire logic [7:0] value,
  input  wire logic [7:0] threshold,
  output logic            hit
);

  // NTC to ground: colder battery means a higher pin voltage
  assign hit = ABOVE ? (value >= threshold) : (value <= threshold);

endmodule

`default_nettype wire
